// ### common/pmc_map.svh
// Command codes, field positions, reset values and timing counts of the misc configuration bank
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH
`define PMC_CMD_MISC 8'hED
`define PMC_CMD_OVR 8'hEE
`define PMC_CMD_ADDR 8'hEF
`define PMC_CMD_CRC 8'hF0
`define PMC_MISC_PEC 15
`define PMC_MISC_SDRL 14
`define PMC_MISC_FRRL 13
`define PMC_MISC_PINSEL 12
`define PMC_MISC_PULLUP_N 3
`define PMC_MISC_FCMODE 2
`define PMC_MISC_RES_HI 1
`define PMC_MISC_RES_LO 0
`define PMC_MISC_WMASK 16'hF00F
`define PMC_OVR_STACK 12
`define PMC_OVR_SYNC 11
`define PMC_OVR_COMP 9
`define PMC_OVR_ADDR 8
`define PMC_OVR_ILV 5
`define PMC_OVR_TON 3
`define PMC_OVR_IOC 2
`define PMC_OVR_FREQ 1
`define PMC_OVR_VOUT 0
`define PMC_OVR_WMASK 16'h1F3F
`define PMC_RSV_ADDR0 7'h0C
`define PMC_RSV_ADDR1 7'h28
`define PMC_RSV_ADDR2 7'h37
`define PMC_RSV_ADDR3 7'h61
`define PMC_CRC_POLY 16'h8005
`define PMC_CRC_INIT 16'h0000
`define PMC_NVM_WORDS 8
`define PMC_FCNT_W 8
`endif

// ### common/pmc_pkg.sv
// Types shared by the misc configuration bank
package pmc_pkg;
  typedef enum logic [1:0] {PMC_IDLE = 2'b00, PMC_LOAD = 2'b01, PMC_CRC = 2'b11} pmc_state_type;
  typedef enum logic [1:0] {PMC_RES12 = 2'b00, PMC_RES10 = 2'b01, PMC_RES8 = 2'b10, PMC_RES6 = 2'b11} pmc_res_type;
endpackage

// ### hw/pmc_crc16.sv
// CRC-16 engine, one 16-bit word per clock, MSB first
`timescale 1ns/1ps
`include "pmc_map.svh"
module pmc_crc16
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  input wire logic start,
  input wire logic word_vld,
  input wire logic [15:0] word_in,
  // Result
  output logic [15:0] crc
);
  logic [15:0] crc_ff;
  logic [15:0] nxt_crc;

  always_comb
  begin
    nxt_crc = crc_ff;
    for (int i = 15; i >= 0; i--)
    begin
      if (nxt_crc[15] ^ word_in[i])
        nxt_crc = {nxt_crc[14:0], 1'b0} ^ `PMC_CRC_POLY;
      else
        nxt_crc = {nxt_crc[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      crc_ff <= `PMC_CRC_INIT;
    else if (start)
      crc_ff <= `PMC_CRC_INIT;
    else if (word_vld)
      crc_ff <= nxt_crc;
  end

  assign crc = crc_ff;
endmodule

// ### hw/pmc_fault_counter.sv
// Fault counter with decrement or clear on a fault-free PWM cycle
`timescale 1ns/1ps
`include "pmc_map.svh"
module pmc_fault_counter
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // PWM events
  input wire logic pwm_cycle,
  input wire logic fault_seen,
  input wire logic clear_mode,
  // Count
  output logic [`PMC_FCNT_W-1:0] count
);
  logic [`PMC_FCNT_W-1:0] count_ff;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      count_ff <= '0;
    else if (pwm_cycle)
    begin
      if (fault_seen)
      begin
        if (count_ff != {`PMC_FCNT_W{1'b1}})
          count_ff <= count_ff + 1'b1;
      end
      else if (clear_mode)
        count_ff <= '0;
      else if (count_ff != '0)
        count_ff <= count_ff - 1'b1;
    end
  end

  assign count = count_ff;
endmodule

// ### hw/pmc_misc_config.sv
// Misc configuration command bank: options, strap override, bus address and Nonvolatile_settings_crc
// Summary of operation
// - PEC bit 0 accepts transactions without PEC; 1 rejects them as bad PEC.
// - Shutdown reload bit reloads commanded voltage with boot voltage on shutdown.
// - Fault-restart reload bit reloads boot voltage on retry restart after fault.
// - Pin select 0 gives power-good with pullup off; 1 gives reset output.
// - In reset-output mode pullup is on when pullup control bit is 0.
// - Fault-free PWM cycle decrements fault counter, or clears it in clear mode.
// - Resolution field 00/01/10/11 selects 12, 10, 8 or 6 bit conversions.
// - A set override bit keeps the strapped value instead of NVM values.
// - Straps are sampled only at power-on reset; override writes act at once, but the bus address source is picked from NVM bit 8 at load only.
// - Bits 12 and 11 pick the source of stacking and sync settings.
// - Bits 9 and 8 pick the source of compensation and bus address.
// - Bits 5 and 3 pick the source of interleave and turn-on rise.
// - Bit 2 picks the source of both overcurrent limits together.
// - Bit 1 picks switching frequency source; bit 0 the output-voltage group.
// - Address register holds 7 bits, bit 7 reads zero, loaded from NVM or strap.
// - A new address is answered from the next transaction onward.
// - The four reserved bus addresses cannot be programmed.
// - Checksum is read-only and refreshed at boot and after store or restore.
// - Checksum is CRC-16 over NVM settings with polynomial 0x8005.
`timescale 1ns/1ps
`include "pmc_map.svh"
module pmc_misc_config
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Decoded command port from the bus front end
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  output logic cmd_ack,
  output logic cmd_invalid_data,
  output logic cmd_unsupported,
  // Transaction PEC check
  input wire logic txn_done,
  input wire logic txn_has_pec,
  output logic txn_accept,
  output logic txn_pec_error,
  // Current bus address for the front end
  output logic [6:0] bus_address,
  // NVM image and operations
  input wire logic [15:0] nvm_misc,
  input wire logic [15:0] nvm_ovr,
  input wire logic [6:0] nvm_addr,
  input wire logic nvm_store_done,
  input wire logic nvm_restore,
  output logic [2:0] nvm_word_sel,
  input wire logic [15:0] nvm_word,
  // Pin straps
  input wire logic [6:0] strap_addr,
  // Regulator events
  input wire logic shutdown_evt,
  input wire logic fault_restart_evt,
  input wire logic fault_retry_mode,
  input wire logic pwm_cycle,
  input wire logic pwm_fault,
  // Steering outputs
  output logic boot_voltage_reload,
  output logic shared_status_pin_rst_mode,
  output logic shared_status_pin_pullup_en,
  output logic [1:0] converter_resolution_select,
  output logic [3:0] converter_resolution_bits,
  output logic [`PMC_FCNT_W-1:0] fault_count,
  output logic [12:0] use_strap_value,
  output logic load_settings
);
  logic [15:0] misc_ff;
  logic [15:0] ovr_ff;
  logic [6:0] addr_ff;
  logic [6:0] strap_addr_ff;
  logic [15:0] crc_ff;
  logic [15:0] rdata_ff;
  logic ack_ff;
  logic inv_ff;
  logic uns_ff;
  logic acc_ff;
  logic pecerr_ff;
  logic reload_ff;
  logic load_ff;
  logic [2:0] idx_ff;
  logic crc_last_ff;
  logic restore_pend_ff;
  logic store_pend_ff;
  pmc_pkg::pmc_state_type state_ff;
  pmc_pkg::pmc_state_type nxt_state;
  logic [15:0] crc_val;
  logic addr_bad;
  logic load_req;

  assign load_req = nvm_restore || restore_pend_ff || (state_ff == pmc_pkg::PMC_IDLE && load_ff);
  assign addr_bad = (cmd_wdata[6:0] == `PMC_RSV_ADDR0) || (cmd_wdata[6:0] == `PMC_RSV_ADDR1) ||
                    (cmd_wdata[6:0] == `PMC_RSV_ADDR2) || (cmd_wdata[6:0] == `PMC_RSV_ADDR3);

  // Boot and restore sequencing: load settings then refresh checksum
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      pmc_pkg::PMC_IDLE:
        if (load_req)
          nxt_state = pmc_pkg::PMC_LOAD;
        else if (nvm_store_done || store_pend_ff)
          nxt_state = pmc_pkg::PMC_CRC;
      pmc_pkg::PMC_LOAD:
        nxt_state = pmc_pkg::PMC_CRC;
      pmc_pkg::PMC_CRC:
        if (idx_ff == 3'(`PMC_NVM_WORDS - 1))
          nxt_state = pmc_pkg::PMC_IDLE;
      default:
        nxt_state = pmc_pkg::PMC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state_ff <= pmc_pkg::PMC_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Power-on request held until the first idle cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      load_ff <= 1'b1;
    else if (state_ff == pmc_pkg::PMC_IDLE)
      load_ff <= 1'b0;
  end

  // Restore or store seen mid-sequence is held until the sequencer is idle again
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      restore_pend_ff <= 1'b0;
    else if (nvm_restore && state_ff != pmc_pkg::PMC_IDLE)
      restore_pend_ff <= 1'b1;
    else if (state_ff == pmc_pkg::PMC_IDLE)
      restore_pend_ff <= 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      store_pend_ff <= 1'b0;
    else if (nvm_store_done && state_ff != pmc_pkg::PMC_IDLE)
      store_pend_ff <= 1'b1;
    else if (state_ff == pmc_pkg::PMC_IDLE)
      store_pend_ff <= 1'b0;
  end

  // Straps captured once after power-on reset release
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      strap_addr_ff <= '0;
    else if (load_ff)
      strap_addr_ff <= strap_addr;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      idx_ff <= '0;
    else if (state_ff != pmc_pkg::PMC_CRC)
      idx_ff <= '0;
    else
      idx_ff <= idx_ff + 3'h1;
  end

  pmc_crc16 u_crc
  (
    .clk(clk),
    .arst_n(arst_n),
    .start(state_ff != pmc_pkg::PMC_CRC),
    .word_vld(state_ff == pmc_pkg::PMC_CRC),
    .word_in(nvm_word),
    .crc(crc_val)
  );

  // Last word is folded on the final CRC cycle, so the result is taken one cycle later
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      crc_last_ff <= 1'b0;
    else
      crc_last_ff <= (state_ff == pmc_pkg::PMC_CRC) && (idx_ff == 3'(`PMC_NVM_WORDS - 1));
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      crc_ff <= '0;
    else if (crc_last_ff)
      crc_ff <= crc_val;
  end

  // Options word
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      misc_ff <= '0;
    else if (state_ff == pmc_pkg::PMC_LOAD)
      misc_ff <= nvm_misc & `PMC_MISC_WMASK;
    else if (cmd_wr && cmd_code == `PMC_CMD_MISC)
      misc_ff <= cmd_wdata & `PMC_MISC_WMASK;
  end

  // Override word; writes act at once without new strap detection, except the bus address source, picked only at load
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ovr_ff <= '0;
    else if (state_ff == pmc_pkg::PMC_LOAD)
      ovr_ff <= nvm_ovr & `PMC_OVR_WMASK;
    else if (cmd_wr && cmd_code == `PMC_CMD_OVR)
      ovr_ff <= cmd_wdata & `PMC_OVR_WMASK;
  end

  // Bus address from NVM or strap at load, or by byte write
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      addr_ff <= '0;
    else if (state_ff == pmc_pkg::PMC_LOAD)
      addr_ff <= nvm_ovr[`PMC_OVR_ADDR] ? strap_addr_ff : nvm_addr;
    else if (cmd_wr && cmd_code == `PMC_CMD_ADDR && !addr_bad)
      addr_ff <= cmd_wdata[6:0];
  end

  // Acknowledge one cycle after each request
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ack_ff <= 1'b0;
    else
      ack_ff <= cmd_wr || cmd_rd;
  end

  // Reserved address writes are answered as invalid data
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      inv_ff <= 1'b0;
    else
      inv_ff <= cmd_wr && cmd_code == `PMC_CMD_ADDR && addr_bad;
  end

  // Checksum writes and codes outside this bank are unsupported
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      uns_ff <= 1'b0;
    else
      uns_ff <= (cmd_wr && cmd_code == `PMC_CMD_CRC) ||
                ((cmd_wr || cmd_rd) && (cmd_code < `PMC_CMD_MISC || cmd_code > `PMC_CMD_CRC));
  end

  // Read data stands until the next read
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_ff <= '0;
    else if (cmd_rd)
    begin
      case (cmd_code)
        `PMC_CMD_MISC: rdata_ff <= misc_ff;
        `PMC_CMD_OVR: rdata_ff <= ovr_ff;
        `PMC_CMD_ADDR: rdata_ff <= {9'h000, addr_ff};
        `PMC_CMD_CRC: rdata_ff <= crc_ff;
        default: rdata_ff <= 16'h0000;
      endcase
    end
  end

  // PEC policy check on each finished transaction
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      acc_ff <= 1'b0;
    else
      acc_ff <= txn_done && (txn_has_pec || !misc_ff[`PMC_MISC_PEC]);
  end

  // Missing check byte is refused only when the policy bit asks for it
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pecerr_ff <= 1'b0;
    else
      pecerr_ff <= txn_done && !txn_has_pec && misc_ff[`PMC_MISC_PEC];
  end

  // Boot voltage reload request
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reload_ff <= 1'b0;
    else
      reload_ff <= (shutdown_evt && misc_ff[`PMC_MISC_SDRL]) ||
                   (fault_restart_evt && fault_retry_mode && misc_ff[`PMC_MISC_FRRL]);
  end

  pmc_fault_counter u_fcnt
  (
    .clk(clk),
    .arst_n(arst_n),
    .pwm_cycle(pwm_cycle),
    .fault_seen(pwm_fault),
    .clear_mode(misc_ff[`PMC_MISC_FCMODE]),
    .count(fault_count)
  );

  always_comb
  begin
    case (pmc_pkg::pmc_res_type'(misc_ff[`PMC_MISC_RES_HI:`PMC_MISC_RES_LO]))
      pmc_pkg::PMC_RES12: converter_resolution_bits = 4'hC;
      pmc_pkg::PMC_RES10: converter_resolution_bits = 4'hA;
      pmc_pkg::PMC_RES8: converter_resolution_bits = 4'h8;
      pmc_pkg::PMC_RES6: converter_resolution_bits = 4'h6;
      default: converter_resolution_bits = 4'hC;
    endcase
  end

  assign cmd_rdata = rdata_ff;
  assign cmd_ack = ack_ff;
  assign cmd_invalid_data = inv_ff;
  assign cmd_unsupported = uns_ff;
  assign txn_accept = acc_ff;
  assign txn_pec_error = pecerr_ff;
  assign bus_address = addr_ff;
  assign nvm_word_sel = idx_ff;
  assign boot_voltage_reload = reload_ff;
  assign shared_status_pin_rst_mode = misc_ff[`PMC_MISC_PINSEL];
  assign shared_status_pin_pullup_en = misc_ff[`PMC_MISC_PINSEL] && !misc_ff[`PMC_MISC_PULLUP_N];
  assign converter_resolution_select = misc_ff[`PMC_MISC_RES_HI:`PMC_MISC_RES_LO];
  assign use_strap_value = ovr_ff[12:0];
  assign load_settings = (state_ff == pmc_pkg::PMC_LOAD);
endmodule

// ### testbench/pmc_misc_assertions.sv
// Port-level checks for the misc configuration bank
`timescale 1ns/1ps
module pmc_misc_assertions
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Command port
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_ack,
  input wire logic cmd_invalid_data,
  input wire logic cmd_unsupported,
  // Transaction check
  input wire logic txn_done,
  input wire logic txn_has_pec,
  input wire logic txn_accept,
  input wire logic txn_pec_error,
  // Status and steering
  input wire logic [6:0] bus_address,
  input wire logic shutdown_evt,
  input wire logic fault_restart_evt,
  input wire logic boot_voltage_reload,
  input wire logic shared_status_pin_rst_mode,
  input wire logic shared_status_pin_pullup_en,
  input wire logic [1:0] converter_resolution_select,
  input wire logic [3:0] converter_resolution_bits
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic aw;
  logic rsv;
  assign aw = cmd_wr && cmd_code == 8'hEF;
  assign rsv = cmd_wdata[6:0] inside {7'h0C, 7'h28, 7'h37, 7'h61};
  chk_req_acked: assert property ((cmd_wr || cmd_rd) |=> cmd_ack)
    else $error("request not acknowledged");
  chk_addr_taken: assert property (aw && !rsv |=> bus_address == $past(cmd_wdata[6:0]))
    else $error("address not updated");
  chk_rsv_refused: assert property (aw && rsv |=> cmd_invalid_data && $stable(bus_address))
    else $error("reserved address taken");
  chk_crc_readonly: assert property (cmd_wr && cmd_code == 8'hF0 |=> cmd_unsupported)
    else $error("checksum write not refused");
  chk_pec_verdict: assert property (txn_done |=> txn_accept != txn_pec_error)
    else $error("no single verdict");
  chk_pec_present: assert property (txn_done && txn_has_pec |=> txn_accept)
    else $error("transaction with check byte refused");
  chk_power_good_indicator_pullup: assert property (!shared_status_pin_rst_mode |-> !shared_status_pin_pullup_en)
    else $error("pullup on in power-good mode");
  chk_pin_role: assert property (cmd_wr && cmd_code == 8'hED |=> shared_status_pin_rst_mode == $past(cmd_wdata[12])
    && shared_status_pin_pullup_en == ($past(cmd_wdata[12]) && !$past(cmd_wdata[3])))
    else $error("pin role wrong");
  chk_res_width: assert property (converter_resolution_bits == 4'hC - {1'b0, converter_resolution_select, 1'b0})
    else $error("resolution width wrong");
  chk_reload_cause: assert property (boot_voltage_reload |-> $past(shutdown_evt || fault_restart_evt))
    else $error("reload without event");
  cover property (aw && rsv);
  cover property (txn_done && !txn_has_pec ##1 txn_pec_error);
  cover property (boot_voltage_reload);
endmodule

// ### testbench/pmc_host_model.sv
// Host model issuing word and byte commands
`timescale 1ns/1ps
module pmc_host_model
(
  // Clock
  input wire logic clk,
  // Requests
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  // Answers
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_ack,
  input wire logic cmd_invalid_data,
  input wire logic cmd_unsupported
);
  logic [15:0] rq;
  logic inv_q;
  logic uns_q;
  logic got;
  initial
  begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, input int gap);
    int n;
    begin
      repeat (gap) @(posedge clk);
      @(posedge clk);
      cmd_wr <= w;
      cmd_rd <= !w;
      cmd_code <= c;
      if (c == 8'hED)
        cmd_wdata <= d & 16'hF00F;
      else if (c == 8'hEE)
        cmd_wdata <= d & 16'h1F3F;
      else
        cmd_wdata <= d;
      @(posedge clk);
      cmd_wr <= 1'b0;
      cmd_rd <= 1'b0;
      cmd_wdata <= ~d;
      got = 1'b0;
      n = 0;
      while (!got && n < 8)
      begin
        @(posedge clk);
        got = (cmd_ack === 1'b1);
        n++;
      end
      rq = cmd_rdata;
      inv_q = cmd_invalid_data;
      uns_q = cmd_unsupported;
    end
  endtask
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the misc configuration bank
`timescale 1ns/1ps
module testbench;
  logic clk, arst_n, cmd_wr, cmd_rd, cmd_ack, cmd_invalid_data, cmd_unsupported, load_settings;
  logic txn_done, txn_has_pec, txn_accept, txn_pec_error, nvm_store_done, nvm_restore;
  logic shutdown_evt, fault_restart_evt, fault_retry_mode, pwm_cycle, pwm_fault, boot_voltage_reload;
  logic shared_status_pin_rst_mode, shared_status_pin_pullup_en;
  logic [7:0] cmd_code, fault_count, c;
  logic [15:0] cmd_wdata, cmd_rdata, nvm_misc, nvm_ovr, nvm_word, d, nvm_seed;
  logic [6:0] bus_address, nvm_addr, strap_addr;
  logic [2:0] nvm_word_sel;
  logic [1:0] converter_resolution_select;
  logic [3:0] converter_resolution_bits;
  logic [12:0] use_strap_value;
  int err_total, total_checks;
  pmc_misc_config pmc_misc_config_i (.*);
  pmc_host_model host_i (.*);
  // NVM image word is nvm_seed XOR its index
  assign nvm_word = nvm_seed ^ {13'h0000, nvm_word_sel};
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want)
    begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic x(input logic w, input logic [7:0] cc, input logic [15:0] dd);
    host_i.xfer(w, cc, dd, 0);
    chk(host_i.got, 1'b1);
  endtask
  function automatic logic [15:0] crc_exp(input logic [15:0] seed);
    logic [15:0] r;
    logic [15:0] w;
    r = 16'h0000;
    for (int i = 0; i < 8; i++)
    begin
      w = seed ^ 16'(i);
      for (int b = 15; b >= 0; b--)
        r = {r[14:0], 1'b0} ^ ((r[15] ^ w[b]) ? 16'h8005 : 16'h0000);
    end
    return r;
  endfunction
  task automatic txn(input logic p, input logic e);
    @(posedge clk);
    txn_done <= 1'b1;
    txn_has_pec <= p;
    @(posedge clk);
    txn_done <= 1'b0;
    @(posedge clk);
    chk(txn_pec_error, e);
    chk(txn_accept, !e);
  endtask
  task automatic ev(input logic s, input logic f, input logic r, input logic want);
    @(posedge clk);
    shutdown_evt <= s;
    fault_restart_evt <= f;
    fault_retry_mode <= r;
    @(posedge clk);
    shutdown_evt <= 1'b0;
    fault_restart_evt <= 1'b0;
    @(posedge clk);
    chk(boot_voltage_reload, want);
  endtask
  task automatic pw(input logic f);
    @(posedge clk);
    pwm_cycle <= 1'b1;
    pwm_fault <= f;
    @(posedge clk);
    pwm_cycle <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_boot();
    chk(bus_address, 7'h33);
    chk(use_strap_value, 13'h0125);
    chk(converter_resolution_select, 2'b10);
    chk(shared_status_pin_pullup_en, 1'b1);
    x(0, 8'hF0, 16'h0000);
    chk(host_i.rq, crc_exp(16'h1234));
  endtask
  logic [15:0] d_tab [4] = '{16'h0008, 16'h1001, 16'h100A, 16'h0003};
  task automatic t_misc();
    x(1, 8'hED, 16'hF00F);
    x(0, 8'hED, 16'h0000);
    chk(host_i.rq, 16'hF00F);
    foreach (d_tab[i])
    begin
      d = d_tab[i];
      x(1, 8'hED, d);
      chk(shared_status_pin_rst_mode, d[12]);
      chk(shared_status_pin_pullup_en, d[12] & !d[3]);
      chk(converter_resolution_bits, 4'hC - {1'b0, d[1:0], 1'b0});
    end
  endtask
  task automatic t_pec();
    x(1, 8'hED, 16'h8000);
    txn(0, 1);
    txn(1, 0);
    x(1, 8'hED, 16'h0000);
    txn(0, 0);
  endtask
  logic [6:0] r_tab [4] = '{7'h0C, 7'h28, 7'h37, 7'h61};
  task automatic t_addr();
    host_i.xfer(1, 8'hEF, 16'h00A5, 3);
    chk(bus_address, 7'h25);
    chk(host_i.inv_q, 1'b0);
    x(0, 8'hEF, 16'h0000);
    chk(host_i.rq, 16'h0025);
    foreach (r_tab[i])
    begin
      x(1, 8'hEF, {9'h000, r_tab[i]});
      chk(host_i.inv_q, 1'b1);
      chk(bus_address, 7'h25);
    end
  endtask
  task automatic t_crc();
    x(1, 8'hF0, 16'h0000);
    chk(host_i.uns_q, 1'b1);
    @(posedge clk);
    nvm_seed <= 16'h4321;
    nvm_store_done <= 1'b1;
    @(posedge clk);
    nvm_store_done <= 1'b0;
    repeat (12) @(posedge clk);
    x(0, 8'hF0, 16'h0000);
    chk(host_i.rq, crc_exp(16'h4321));
  endtask
  task automatic t_restore();
    strap_addr <= 7'h11;
    x(1, 8'hEE, 16'hFFFF);
    chk(use_strap_value, 13'h1F3F);
    @(posedge clk);
    nvm_restore <= 1'b1;
    @(posedge clk);
    nvm_restore <= 1'b0;
    @(posedge clk);
    chk(load_settings, 1'b1);
    repeat (11) @(posedge clk);
    chk(use_strap_value, 13'h0125);
    chk(bus_address, 7'h33);
  endtask
  task automatic t_events();
    x(1, 8'hED, 16'h6000);
    ev(1, 0, 0, 1);
    ev(0, 1, 1, 1);
    ev(0, 1, 0, 0);
    x(1, 8'hED, 16'h0000);
    ev(1, 0, 0, 0);
    ev(0, 1, 1, 0);
    pw(1);
    pw(1);
    c = fault_count;
    pw(0);
    chk(fault_count, c - 8'h01);
    x(1, 8'hED, 16'h0004);
    pw(1);
    pw(0);
    chk(fault_count, 8'h00);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    wrap_up();
  end
  initial
  begin
    {arst_n, txn_done, txn_has_pec, nvm_store_done, nvm_restore} = 5'h00;
    {shutdown_evt, fault_restart_evt, fault_retry_mode, pwm_cycle, pwm_fault} = 5'h00;
    nvm_seed = 16'h1234;
    nvm_misc = 16'h5006;
    nvm_ovr = 16'h0125;
    nvm_addr = 7'h40;
    strap_addr = 7'h33;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (12) @(posedge clk);
    t_boot();
    t_misc();
    t_pec();
    t_addr();
    t_crc();
    t_restore();
    t_events();
    wrap_up();
  end
endmodule
bind pmc_misc_config pmc_misc_assertions pmc_misc_assertions_i (.*);
